// ===== design/kbh_top.sv
// keyboard host interface: host ports, two serial receivers, a byte FIFO
// and the command interpreter; inputs are synchronous to mclk_i
`timescale 1ns/1ps
`include "kbh_map.svh"

// byte FIFO between the receivers and the output buffer
module kbh_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr, rptr, next_wptr, next_rptr;

    // extra pointer bit tells full from empty
    assign in_ready_o  = (wptr - rptr) != (AW+1)'(DEPTH);
    assign out_valid_o = wptr != rptr;
    assign out_data_o  = mem[rptr[AW-1:0]];

    always_comb begin
        next_wptr = wptr + (AW+1)'(in_valid_i & in_ready_o);
        next_rptr = rptr + (AW+1)'(out_valid_o & out_ready_i);
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
        end
    end

    // storage carries no reset; only the pointers matter
    always_ff @(posedge mclk_i) begin
        if (in_valid_i & in_ready_o) begin
            mem[wptr[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// Overview of operation
// - receive serial bytes from both peripherals, check parity, fill buffer
// - raise interrupt on buffer load, gated by command byte enables
// - no further byte to a peripheral before it acknowledged the last or the time-out expired
// - output buffer is read-only at data address, read when full
// - data address write is data, command address write is command
// - data bytes go to keyboard unless a command awaits its parameter
// - status register at command address, read has no side effect
// - status bit 0 output full, bit 1 input full
// - status bit 2 mirrors command byte system flag, zero after reset
// - status bit 4 low while the command byte disables the keyboard
// - status bit 5 marks a buffered byte from the auxiliary device
// - status bit 6 flags a peripheral time-out
// - status bit 7 flags a byte received with even parity
// - command 20h returns command byte, 60h writes it from next data
// - command byte: aux disable, kbd disable, sys, two int enables
// - password test answers FAh when loaded, F1h otherwise
// - password load takes data bytes until a zero byte
// - password enable compares keystrokes against stored password
// - aux interface test returns codes 00 to 04
// - self test returns 55h
// - keyboard interface test returns codes 00 to 04
// - keyboard interface test returns 04 for data stuck high
// - ADh disables and AEh enables the keyboard interface
// - after D1h, next data bit 1 sets the address line 20 gate
// - FXh with even code pulses cpu reset low for 6 us
module kbh_top #(
    parameter int TMO_CYC = `KBH_TMO_CYC
) (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic        [7:0] io_addr_i,
    input  wire logic              io_rd_i,
    input  wire logic              io_wr_i,
    input  wire kbh_pkg::kbh_byte_t io_wdata_i,
    output kbh_pkg::kbh_byte_t     io_rdata_o,
    output logic                   kbd_irq_o,
    output logic                   aux_irq_o,
    input  wire logic        [1:0] ps_clk_i,
    input  wire logic        [1:0] ps_dat_i,
    output logic             [1:0] ps_clk_o,
    output logic             [1:0] ps_clk_oe_n_o,
    output logic             [1:0] ps_dat_o,
    output logic             [1:0] ps_dat_oe_n_o,
    output kbh_pkg::kbh_byte_t     tx_data_o,
    output logic             [1:0] tx_valid_o,
    input  wire logic        [1:0] tx_ack_i,
    output logic                   addr_line_twenty_gate_o,
    output logic                   cpu_reset_line_n_o
);
    import kbh_pkg::*;

    localparam logic [16:0] TMO_LAST  = 17'(TMO_CYC - 1);
    localparam logic [16:0] RST_LAST  = 17'(`KBH_RST_CYC - 1);
    localparam logic [16:0] TEST_LAST = 17'(`KBH_TEST_CYC - 1);

    kbh_state_e state, next_state;
    kbh_byte_t  cb, next_cb, ob, next_ob, inb, next_inb;
    kbh_byte_t  resp, next_resp, pend, next_pend, txb, next_txb;
    logic       obf, next_obf, ibf, next_ibf, cd, next_cd;
    logic       ob_aux, next_ob_aux, perr, next_perr, tmo, next_tmo;
    logic       tx_aux, next_tx_aux, tst_ch, next_tst_ch;
    logic       tst_ph, next_tst_ph, gate, next_gate, rst_n, next_rst_n;
    logic       pw_on, next_pw_on;
    logic [3:0] pw_len, next_pw_len, pw_idx, next_pw_idx;
    logic [16:0] tmr, next_tmr;
    kbh_byte_t  pw_mem [`KBH_PW_LEN];
    logic       pw_we;

    logic       rx_hold [2];
    logic [8:0] rx_byte [2];
    logic [1:0] rx_tmo, take, inhibit;
    logic       f_ready, f_valid, f_pop, drive_lo;
    logic [9:0] f_in, f_out;

    // a parked byte holds its clock low, so the FIFO stalls the peripheral
    assign take[0] = rx_hold[0] & f_ready;
    assign take[1] = rx_hold[1] & ~rx_hold[0] & f_ready;
    assign f_in    = rx_hold[0] ? {1'b0, rx_byte[0]} : {1'b1, rx_byte[1]};
    assign drive_lo = (state == ST_TEST) & tst_ph;
    assign inhibit[0] = rx_hold[0] | cb[`KBH_CB_KDIS];
    assign inhibit[1] = rx_hold[1] | cb[`KBH_CB_ADIS];

    // one receiver per channel: start, 8 data lsb first, parity, stop
    for (genvar c = 0; c < 2; c++) begin : g_rx
        logic        clk_q, next_clk_q, hold, next_hold, tp;
        logic [10:0] sh, next_sh;
        logic [3:0]  cnt, next_cnt;
        logic [16:0] rt, next_rt;
        logic [8:0]  hb, next_hb;

        always_comb begin
            next_clk_q = ps_clk_i[c];
            next_sh    = sh;
            next_cnt   = cnt;
            next_rt    = rt;
            next_hold  = hold & ~take[c];
            next_hb    = hb;
            tp         = 1'b0;
            if (clk_q & ~ps_clk_i[c]) begin
                next_sh  = {ps_dat_i[c], sh[10:1]};
                next_cnt = cnt + 4'h1;
                next_rt  = '0;
            end else if (cnt == 4'hB) begin
                next_cnt = '0;
                // framing must be good; parity error kept with byte
                if (!sh[0] && sh[10]) begin
                    next_hold = 1'b1;
                    next_hb   = {~^sh[9:1], sh[8:1]};
                end
            end else if (cnt != 4'h0) begin
                // a stalled frame is dropped and reported
                if (rt == TMO_LAST) begin
                    next_cnt = '0;
                    next_rt  = '0;
                    tp       = 1'b1;
                end else begin
                    next_rt = rt + 17'h1;
                end
            end
        end

        always_ff @(posedge mclk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                clk_q <= 1'b1;
                {sh, cnt, rt, hold, hb} <= '0;
            end else begin
                clk_q <= next_clk_q;
                {sh, cnt, rt, hold, hb} <=
                    {next_sh, next_cnt, next_rt, next_hold, next_hb};
            end
        end

        assign rx_hold[c]       = hold;
        assign rx_byte[c]       = hb;
        assign rx_tmo[c]        = tp;
        assign ps_clk_o[c]      = 1'b0;
        assign ps_dat_o[c]      = 1'b0;
        assign ps_clk_oe_n_o[c] = ~(inhibit[c] | drive_lo);
        assign ps_dat_oe_n_o[c] = ~drive_lo;
    end

    kbh_fifo #(.WIDTH(10), .DEPTH(16), .AW(4)) u_fifo (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (rx_hold[0] | rx_hold[1]),
        .in_data_i   (f_in),
        .in_ready_o  (f_ready),
        .out_valid_o (f_valid),
        .out_data_o  (f_out),
        .out_ready_i (f_pop)
    );

    // host read mux; status read changes nothing
    always_comb begin
        if (io_addr_i == `KBH_ADDR_CMD) begin
            io_rdata_o = {perr, tmo, obf & ob_aux, ~cb[`KBH_CB_KDIS],
                          cd, cb[`KBH_CB_SYS], ibf, obf};
        end else begin
            io_rdata_o = ob;
        end
    end

    assign kbd_irq_o  = obf & ~ob_aux & cb[0];
    assign aux_irq_o  = obf & ob_aux & cb[1];
    assign tx_data_o  = txb;
    assign tx_valid_o = (state == ST_TX) ? {tx_aux, ~tx_aux} : 2'b00;
    assign addr_line_twenty_gate_o = gate;
    assign cpu_reset_line_n_o      = rst_n;

    // command interpreter, output buffer loading and password match
    always_comb begin
        next_state  = state;
        {next_cb, next_ob, next_inb, next_resp, next_pend, next_txb} =
            {cb, ob, inb, resp, pend, txb};
        {next_obf, next_ibf, next_cd, next_ob_aux, next_tmo} =
            {obf, ibf, cd, ob_aux, tmo};
        {next_perr, next_tx_aux, next_tst_ch, next_tst_ph, next_gate} =
            {perr, tx_aux, tst_ch, tst_ph, gate};
        {next_pw_on, next_pw_len, next_pw_idx} = {pw_on, pw_len, pw_idx};
        next_rst_n  = 1'b1;
        next_tmr    = tmr + 17'h1;
        pw_we       = 1'b0;
        f_pop       = 1'b0;
        if (io_rd_i && io_addr_i == `KBH_ADDR_DATA) begin
            next_obf = 1'b0;
        end
        unique case (state)
            ST_IDLE: begin
                next_tmr = '0;
                if (ibf) begin
                    next_ibf = 1'b0;
                    if (cd) begin
                        next_pend = `KBH_C_NONE;
                        unique case (inb)
                            `KBH_C_RDCB: begin
                                next_resp  = cb;
                                next_state = ST_RESP;
                            end
                            `KBH_C_WRCB: next_pend = inb;
                            `KBH_C_PWTST: begin
                                next_resp  = (pw_len != 4'h0) ?
                                             `KBH_R_PWYES : `KBH_R_PWNO;
                                next_state = ST_RESP;
                            end
                            `KBH_C_PWLD: begin
                                next_pend   = inb;
                                next_pw_len = '0;
                                next_pw_on  = 1'b0;
                            end
                            `KBH_C_PWEN: begin
                                next_pw_on  = pw_len != 4'h0;
                                next_pw_idx = '0;
                            end
                            `KBH_C_ADIS: next_cb[`KBH_CB_ADIS] = 1'b1;
                            `KBH_C_AEN:  next_cb[`KBH_CB_ADIS] = 1'b0;
                            `KBH_C_ATST, `KBH_C_KTST: begin
                                next_tst_ch = inb == `KBH_C_ATST;
                                next_tst_ph = 1'b0;
                                next_state  = ST_TEST;
                            end
                            `KBH_C_SELF: begin
                                next_resp  = `KBH_R_SELF;
                                next_state = ST_RESP;
                            end
                            `KBH_C_KDIS: next_cb[`KBH_CB_KDIS] = 1'b1;
                            `KBH_C_KEN:  next_cb[`KBH_CB_KDIS] = 1'b0;
                            `KBH_C_GATE, `KBH_C_AUXW: next_pend = inb;
                            default: begin
                                // only even codes of the top row reset
                                if (inb[7:4] == 4'hF && !inb[0]) begin
                                    next_rst_n = 1'b0;
                                    next_state = ST_RST;
                                end
                            end
                        endcase
                    end else begin
                        next_pend = `KBH_C_NONE;
                        unique case (pend)
                            `KBH_C_WRCB: next_cb = inb;
                            `KBH_C_PWLD: begin
                                // zero ends loading; extra bytes dropped
                                if (inb != 8'h00) begin
                                    next_pend = pend;
                                    if (pw_len != 4'(`KBH_PW_LEN)) begin
                                        pw_we       = 1'b1;
                                        next_pw_len = pw_len + 4'h1;
                                    end
                                end
                            end
                            `KBH_C_GATE: next_gate = inb[1];
                            default: begin
                                next_txb    = inb;
                                next_tx_aux = pend == `KBH_C_AUXW;
                                next_state  = ST_TX;
                            end
                        endcase
                    end
                end
            end
            ST_TX: begin
                // hold until the peripheral acknowledges this byte or the time-out expires
                if (tx_ack_i[tx_aux]) begin
                    next_state = ST_IDLE;
                end else if (tmr == TMO_LAST) begin
                    next_tmo   = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_RESP: begin
                if (!obf) begin
                    next_ob     = resp;
                    next_ob_aux = 1'b0;
                    next_perr   = 1'b0;
                    next_obf    = 1'b1;
                    next_state  = ST_IDLE;
                end
            end
            ST_TEST: begin
                // released lines must read high, driven lines low
                if (tmr == TEST_LAST) begin
                    next_tmr    = '0;
                    next_tst_ph = 1'b1;
                    if (!tst_ph) begin
                        if (!ps_clk_i[tst_ch]) begin
                            next_resp  = `KBH_R_CLKLO;
                            next_state = ST_RESP;
                        end else if (!ps_dat_i[tst_ch]) begin
                            next_resp  = `KBH_R_DATLO;
                            next_state = ST_RESP;
                        end
                    end else begin
                        next_state = ST_RESP;
                        if (ps_clk_i[tst_ch]) begin
                            next_resp = `KBH_R_CLKHI;
                        end else if (ps_dat_i[tst_ch]) begin
                            next_resp = `KBH_R_DATHI;
                        end else begin
                            next_resp = `KBH_R_OK;
                        end
                    end
                end
            end
            ST_RST: begin
                next_rst_n = 1'b0;
                if (tmr == RST_LAST) begin
                    next_rst_n = 1'b1;
                    next_state = ST_IDLE;
                end
            end
        endcase
        // keystrokes are swallowed while the password is armed
        if (f_valid && pw_on && !f_out[9]) begin
            f_pop = 1'b1;
            if (f_out[7:0] == pw_mem[pw_idx[2:0]]) begin
                next_pw_idx = pw_idx + 4'h1;
                next_pw_on  = (pw_idx + 4'h1) != pw_len;
            end else begin
                next_pw_idx = '0;
            end
        end else if (f_valid && !obf && state != ST_RESP) begin
            f_pop       = 1'b1;
            next_ob     = f_out[7:0];
            next_ob_aux = f_out[9];
            next_perr   = f_out[8];
            next_tmo    = 1'b0;
            next_obf    = 1'b1;
        end
        // a receiver time-out in the clearing cycle still sets the flag
        if (rx_tmo != 2'b00) begin
            next_tmo = 1'b1;
        end
        // host writes set the flag even in the cycle it is consumed
        if (io_wr_i && (io_addr_i == `KBH_ADDR_DATA ||
                        io_addr_i == `KBH_ADDR_CMD)) begin
            next_inb = io_wdata_i;
            next_ibf = 1'b1;
            next_cd  = io_addr_i == `KBH_ADDR_CMD;
        end
    end

    // password store written one byte at a time
    always_ff @(posedge mclk_i) begin
        if (pw_we) begin
            pw_mem[pw_len[2:0]] <= inb;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            cb    <= `KBH_CB_RST;
            pend  <= `KBH_C_NONE;
            rst_n <= 1'b1;
            {obf, ibf, ob_aux, perr, tmo} <= '0;
            {ob, inb, resp, txb, cd, tx_aux, tst_ch, tst_ph} <= '0;
            {gate, pw_on, pw_len, pw_idx, tmr} <= '0;
        end else begin
            state <= next_state;
            {cb, ob, inb, resp, pend, txb} <=
                {next_cb, next_ob, next_inb, next_resp, next_pend, next_txb};
            {obf, ibf, cd, ob_aux, tmo} <=
                {next_obf, next_ibf, next_cd, next_ob_aux, next_tmo};
            {perr, tx_aux, tst_ch, tst_ph, gate} <=
                {next_perr, next_tx_aux, next_tst_ch, next_tst_ph, next_gate};
            {pw_on, pw_len, pw_idx, rst_n, tmr} <=
                {next_pw_on, next_pw_len, next_pw_idx, next_rst_n, next_tmr};
        end
    end
endmodule

// ===== design/kbh_map.svh
// keyboard host interface: port addresses, bit positions, command codes
// and timing counts; included by the package and by the design file
`ifndef KBH_MAP_SVH
`define KBH_MAP_SVH
`define KBH_ADDR_DATA 8'h60
`define KBH_ADDR_CMD  8'h64
// command byte fields
`define KBH_CB_SYS    2
`define KBH_CB_KDIS   4
`define KBH_CB_ADIS   5
`define KBH_CB_RST    8'h00
// host commands
`define KBH_C_RDCB    8'h20
`define KBH_C_WRCB    8'h60
`define KBH_C_PWTST   8'hA4
`define KBH_C_PWLD    8'hA5
`define KBH_C_PWEN    8'hA6
`define KBH_C_ADIS    8'hA7
`define KBH_C_AEN     8'hA8
`define KBH_C_ATST    8'hA9
`define KBH_C_SELF    8'hAA
`define KBH_C_KTST    8'hAB
`define KBH_C_KDIS    8'hAD
`define KBH_C_KEN     8'hAE
`define KBH_C_GATE    8'hD1
`define KBH_C_AUXW    8'hD4
`define KBH_C_NONE    8'h00
// answers
`define KBH_R_SELF    8'h55
`define KBH_R_PWYES   8'hFA
`define KBH_R_PWNO    8'hF1
`define KBH_R_OK      8'h00
`define KBH_R_CLKLO   8'h01
`define KBH_R_CLKHI   8'h02
`define KBH_R_DATLO   8'h03
`define KBH_R_DATHI   8'h04
// timing
`define KBH_CLK_MHZ   40
`define KBH_RST_US    6
`define KBH_RST_CYC   (`KBH_RST_US * `KBH_CLK_MHZ)
`define KBH_TMO_US    2000
`define KBH_TMO_CYC   (`KBH_TMO_US * `KBH_CLK_MHZ)
`define KBH_TEST_CYC  16
`define KBH_PW_LEN    8
`endif

// ===== design/kbh_pkg.sv
// keyboard host interface: shared types
// assumes kbh_map.svh sits on the include path
package kbh_pkg;
`include "kbh_map.svh"
    typedef logic [7:0] kbh_byte_t;
    typedef enum {
        ST_IDLE, ST_TX, ST_RESP, ST_TEST, ST_RST
    } kbh_state_e;
endpackage

// ===== test/kbh_top_asserts.sv
// checker for kbh_top: host port, irq, transmit and reset pulse timing
// bound to every kbh_top; one clock domain, mclk_i
`timescale 1ns/1ps
module kbh_top_asserts (
    input wire logic               mclk_i,
    input wire logic               rstn_i,
    input wire logic         [7:0] io_addr_i,
    input wire logic               io_rd_i,
    input wire logic               io_wr_i,
    input wire kbh_pkg::kbh_byte_t io_rdata_o,
    input wire logic               kbd_irq_o,
    input wire logic               aux_irq_o,
    input wire logic         [1:0] ps_clk_o,
    input wire kbh_pkg::kbh_byte_t tx_data_o,
    input wire logic         [1:0] tx_valid_o,
    input wire logic         [1:0] tx_ack_i,
    input wire logic               cpu_reset_line_n_o
);
    logic [8:0] low_cnt;
    wire        st_sel = io_addr_i == 8'h64;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // length of the running cpu reset pulse, judged when it ends
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) low_cnt <= 9'h000;
        else if (cpu_reset_line_n_o) low_cnt <= 9'h000;
        else low_cnt <= low_cnt + 9'h001;
    end
    property p_kirq; kbd_irq_o && st_sel |-> io_rdata_o[0] && !io_rdata_o[5];
    endproperty
    a_kirq: assert property (p_kirq) else $error("kbd irq status");
    property p_airq; aux_irq_o && st_sel |-> io_rdata_o[0] && io_rdata_o[5];
    endproperty
    a_airq: assert property (p_airq) else $error("aux irq status");
    property p_cmdwr; io_wr_i && st_sel ##1 st_sel |-> io_rdata_o[3] && io_rdata_o[1];
    endproperty
    a_cmdwr: assert property (p_cmdwr) else $error("cmd write flags");
    property p_datwr; io_wr_i && io_addr_i == 8'h60 ##1 st_sel
        |-> io_rdata_o[1] && !io_rdata_o[3]; endproperty
    a_datwr: assert property (p_datwr) else $error("data write flags");
    property p_txhold; tx_valid_o[0] && !tx_ack_i[0]
        |=> tx_valid_o[0] && $stable(tx_data_o); endproperty
    a_txhold: assert property (p_txhold) else $error("tx dropped");
    property p_rdclr; kbd_irq_o && io_rd_i && io_addr_i == 8'h60 |=> !kbd_irq_o;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read kept full");
    property p_rstlen; $rose(cpu_reset_line_n_o) |-> low_cnt == 9'h0F0;
    endproperty
    a_rstlen: assert property (p_rstlen) else $error("reset pulse len");
    property p_od; $rose(tx_valid_o[0]) |-> ##[1:70] !tx_valid_o[0];
    endproperty
    a_od: assert property (p_od) else $error("tx never ended");
    cover property ($fell(cpu_reset_line_n_o));
    cover property (aux_irq_o);
    cover property (tx_valid_o[0] && tx_ack_i[0]);
endmodule
bind kbh_top kbh_top_asserts kbh_top_asserts_i (.*);

// ===== test/kbh_peer.sv
// serial keyboard and aux model: sends frames on request, acks tx bytes
// lines are open drain with pull-ups; device enables are resolved here
`timescale 1ns/1ps
module kbh_peer (
    input  wire logic       mclk_i,
    input  wire logic [1:0] clk_oe_n_i,
    input  wire logic [1:0] dat_oe_n_i,
    input  wire logic [1:0] tx_valid_i,
    output logic      [1:0] clk_o,
    output logic      [1:0] dat_o,
    output logic      [1:0] tx_ack_o = 2'h0
);
    logic [1:0] clk_d = 2'h3;
    logic [1:0] dat_d = 2'h3;
    logic [3:0] wait_cnt = 4'h0;
    // wired-and: pull-up unless a party pulls low
    assign clk_o = clk_d & clk_oe_n_i;
    assign dat_o = dat_d & dat_oe_n_i;
    // n bits of start, data lsb first, parity, stop; bad makes parity even
    task automatic send(input int ch, input logic [7:0] b, input logic bad,
                        input int n);
        logic [10:0] f;
        f = {1'b1, ~^b ^ bad, b, 1'b0};
        while (clk_o[ch] !== 1'b1) @(negedge mclk_i);
        for (int i = 0; i < n; i++) begin
            dat_d[ch] = f[i];
            repeat (4) @(negedge mclk_i);
            clk_d[ch] = 1'b0;
            repeat (4) @(negedge mclk_i);
            clk_d[ch] = 1'b1;
        end
        dat_d[ch] = 1'b1;
        repeat (8) @(negedge mclk_i);
    endtask
    // slow ack: every byte is acked after a short think time
    always @(negedge mclk_i) begin
        wait_cnt <= (tx_valid_i != 2'h0) ? wait_cnt + 4'h1 : 4'h0;
        tx_ack_o <= (wait_cnt == 4'h6) ? tx_valid_i : 2'h0;
    end
endmodule

// ===== test/kbh_top_tb.sv
// testbench for kbh_top: host port tasks, serial peer, random bytes
// inputs change on the falling edge of mclk_i; the peer resolves the lines
`timescale 1ns/1ps
`include "kbh_map.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module kbh_top_tb;
    import kbh_pkg::*;
    logic        mclk_i = 1'b0, rstn_i = 1'b0, io_rd_i = 1'b0, io_wr_i = 1'b0;
    logic  [7:0] io_addr_i = 8'h64;
    kbh_byte_t   io_wdata_i = 8'h00, io_rdata_o, tx_data_o, st, d, e;
    logic        kbd_irq_o, aux_irq_o, cpu_reset_line_n_o;
    logic        addr_line_twenty_gate_o;
    wire   [1:0] ps_clk_i, ps_dat_i, tx_ack_i;
    logic  [1:0] ps_clk_oe_n_o, ps_dat_oe_n_o, tx_valid_o;
    logic [31:0] rs = 32'h9246;
    kbh_byte_t   q[$];
    int          failures = 0, comparisons = 0, n;
    kbh_byte_t   cmds[4] = '{`KBH_C_PWTST, `KBH_C_SELF, `KBH_C_KTST,
                             `KBH_C_ATST};
    kbh_byte_t   ans[4] = '{`KBH_R_PWNO, `KBH_R_SELF, `KBH_R_OK, `KBH_R_OK};
    kbh_top #(.TMO_CYC(64)) kbh_top_i (.mclk_i, .rstn_i, .io_addr_i, .io_rd_i,
        .io_wr_i, .io_wdata_i, .io_rdata_o, .kbd_irq_o, .aux_irq_o, .ps_clk_i,
        .ps_dat_i, .ps_clk_o(), .ps_clk_oe_n_o, .ps_dat_o(), .ps_dat_oe_n_o,
        .tx_data_o, .tx_valid_o, .tx_ack_i, .addr_line_twenty_gate_o,
        .cpu_reset_line_n_o);
    kbh_peer kbh_peer_i (.mclk_i, .clk_oe_n_i(ps_clk_oe_n_o),
        .dat_oe_n_i(ps_dat_oe_n_o), .tx_valid_i(tx_valid_o), .clk_o(ps_clk_i),
        .dat_o(ps_dat_i), .tx_ack_o(tx_ack_i));
    // 40 MHz clock
    initial forever #12.5 mclk_i = ~mclk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one write strobe; address parks on status so polls need no extra step
    task automatic pulse(input kbh_byte_t a, input kbh_byte_t v);
        io_addr_i = a;
        io_wdata_i = v;
        io_wr_i = 1'b1;
        @(negedge mclk_i);
        io_wr_i = 1'b0;
        io_addr_i = 8'h64;
        @(negedge mclk_i);
    endtask
    // write, then wait for the input buffer to drain as the host must
    task automatic wr(input kbh_byte_t a, input kbh_byte_t v);
        pulse(a, v);
        for (int i = 0; i < 50 && io_rdata_o[1] !== 1'b0; i++)
            @(negedge mclk_i);
    endtask
    task automatic rd(input kbh_byte_t a, output kbh_byte_t v);
        io_addr_i = a;
        io_rd_i = 1'b1;
        #1 v = io_rdata_o;
        @(negedge mclk_i);
        io_rd_i = 1'b0;
        io_addr_i = 8'h64;
        @(negedge mclk_i);
    endtask
    // data is read once the full flag is up, or after 200 cycles without it
    task automatic get(output kbh_byte_t s, output kbh_byte_t v);
        for (int i = 0; i < 200 && io_rdata_o[0] !== 1'b1; i++)
            @(negedge mclk_i);
        s = io_rdata_o;
        rd(8'h60, v);
    endtask
    task automatic test_done;
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard, well past the run's length
    initial begin
        repeat (10000) @(posedge mclk_i);
        failures++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (8) @(negedge mclk_i);
        rstn_i = 1'b1;
        rd(8'h64, st);
        `CHK("status reset", 8'h10, st)
        wr(8'h64, `KBH_C_WRCB);
        wr(8'h60, 8'h07);
        rd(8'h64, st);
        `CHK("sys flag", 1'b1, st[2])
        wr(8'h64, `KBH_C_RDCB);
        get(st, d);
        `CHK("cmd byte", 8'h07, d)
        for (int i = 0; i < 4; i++) begin
            wr(8'h64, cmds[i]);
            get(st, d);
            `CHK("answer", ans[i], d)
        end
        wr(8'h64, `KBH_C_PWLD);
        repeat (3) begin
            rs = lfsr(rs);
            wr(8'h60, rs[7:0] | 8'h01);
        end
        wr(8'h60, 8'h00);
        wr(8'h64, `KBH_C_PWTST);
        get(st, d);
        `CHK("pw loaded", `KBH_R_PWYES, d)
        for (int c = 0; c < 2; c++) begin
            if (c == 1) wr(8'h64, `KBH_C_AUXW);
            rs = lfsr(rs);
            pulse(8'h60, rs[7:0]);
            repeat (2) @(negedge mclk_i);
            `CHK("tx valid", 2'h1 << c, tx_valid_o)
            `CHK("tx data", rs[7:0], tx_data_o)
            repeat (12) @(negedge mclk_i);
            `CHK("tx done", 2'h0, tx_valid_o)
        end
        wr(8'h64, `KBH_C_GATE);
        wr(8'h60, 8'h02);
        @(negedge mclk_i);
        `CHK("gate", 1'b1, addr_line_twenty_gate_o)
        wr(8'h64, `KBH_C_KDIS);
        rd(8'h64, st);
        `CHK("inhibit", 1'b0, st[4])
        wr(8'h64, `KBH_C_KEN);
        rd(8'h64, st);
        `CHK("enable", 1'b1, st[4])
        pulse(8'h61, 8'hAA);
        `CHK("unmapped", 1'b0, io_rdata_o[1])
        pulse(8'h64, 8'hFE);
        n = 0;
        repeat (300) begin
            n += (cpu_reset_line_n_o === 1'b0);
            @(negedge mclk_i);
        end
        `CHK("reset pulse", 240, n)
        // fill buffer and FIFO with the host stalled, then drain in order
        for (int i = 0; i < 18; i++) begin
            rs = lfsr(rs);
            q.push_back(rs[7:0]);
            kbh_peer_i.send(0, rs[7:0], 1'b0, 11);
        end
        `CHK("held clock", 1'b0, ps_clk_oe_n_o[0])
        for (int i = 0; i < 18; i++) begin
            get(st, d);
            `CHK("kbd source", 1'b0, st[5])
            e = q.pop_front();
            `CHK("rx byte", e, d)
        end
        kbh_peer_i.send(0, 8'h00, 1'b0, 5);
        repeat (80) @(negedge mclk_i);
        rd(8'h64, st);
        `CHK("timeout", 1'b1, st[6])
        rs = lfsr(rs);
        kbh_peer_i.send(1, rs[7:0], 1'b1, 11);
        repeat (4) @(negedge mclk_i);
        `CHK("aux irq", 1'b1, aux_irq_o)
        get(st, d);
        `CHK("aux status", 3'h5, st[7:5])
        `CHK("aux byte", rs[7:0], d)
        test_done();
    end
endmodule
